// ==== sample_queue_consts.svh ====
// Purpose: named constants for the sample queue
// Assumes: included by bare name from the package and the queue module
// Notes:   definitions only
`ifndef SAMPLE_QUEUE_CONSTS_SVH
`define SAMPLE_QUEUE_CONSTS_SVH

// geometry of the queue
`define SQ_DEPTH        32
`define SQ_PTR_W        5
`define SQ_CNT_W        6
`define SQ_DATA_W       24
`define SQ_SIG_W        22
`define SQ_PAD_W        2

// reset values and fixed patterns
`define SQ_MODE_RESET   2'h0
`define SQ_THR_RESET    5'h00
`define SQ_THR_OFF      5'h00
`define SQ_PAD_ZERO     2'h0
`define SQ_PTR_ZERO     6'h00
`define SQ_DATA_ZERO    24'h00_0000
`define SQ_CNT_ONE      6'h01
`define SQ_CNT_FULL     6'h20

// policy select encodings
`define SQ_MODE_OFF     2'h0
`define SQ_MODE_FULL    2'h1

`endif

// ==== sample_queue_pkg.sv ====
// Purpose: types and shared decoding for the sample queue
// Assumes: constants come from sample_queue_consts.svh
// Notes:   used only through package-qualified names
`include "sample_queue_consts.svh"

package sample_queue_pkg;

  // overflow policy of the queue
  typedef enum logic [1:0] {
    policy_off,
    policy_full,
    policy_update
  } queue_policy_type;

  // two-bit select to policy; both upper codes mean update
  function automatic queue_policy_type decode_policy(input logic [1:0] sel);
    queue_policy_type pol;
    pol = policy_update;
    if (sel == `SQ_MODE_OFF)
      pol = policy_off;
    else if (sel == `SQ_MODE_FULL)
      pol = policy_full;
    return pol;
  endfunction : decode_policy

endpackage : sample_queue_pkg

// ==== sample_queue_with_threshold.sv ====
// Purpose: 32-entry temperature/pressure sample queue with level interrupt
// Assumes: one clock, inputs synchronous to ref_clk_i, result strobes one cycle
// Notes:   control word is written through plain ports, no register bus
//
// Notes on behaviour
// [R1] policy select: 00 off, 01 full, 1x update
// [R2] policy select resets to zero, queue disabled
// [R3] queue holds at most 32 sample pairs
// [R4] entries leave strictly in arrival order
// [R5] filter off: 22 bits plus two zero LSBs
// [R6] filter on: full 24-bit result stored
// [R7] enabled diagnostics replace the compensated result
// [R8] disabled queue holds both pointers at zero
// [R9] disabled queue: no error code insertion
// [R10] full mode drops results when queue full
// [R11] update mode overwrites oldest, read pointer advances
// [R12] five-bit threshold, zero disables level interrupt
// [R13] interrupt when stored count reaches threshold
// [R14] pressure paired with most recent temperature
// [R15] each read removes one entry; no empty reads
// [R16] count is write minus read pointer
`timescale 1ns/1ns
`include "sample_queue_consts.svh"

module sample_queue_with_threshold (
  input  wire logic                    ref_clk_i,          // device clock, 250 MHz
  input  wire logic                    rst_n_i,            // async reset, active low
  // operating control word write port
  input  wire logic                    ctrl_wr_i,          // one-cycle write strobe
  input  wire logic [1:0]              ctrl_mode_i,        // policy select to store
  input  wire logic [`SQ_PTR_W-1:0]    ctrl_threshold_i,   // level threshold to store
  // configuration from the rest of the device
  input  wire logic                    iir_enable_i,       // iir filter switched on
  input  wire logic                    diag_enable_i,      // diagnostics selected in mask
  input  wire logic [`SQ_DATA_W-1:0]   diag_temp_i,        // diagnostic word, temp slot
  input  wire logic [`SQ_DATA_W-1:0]   diag_pres_i,        // diagnostic word, pres slot
  // results from the compensation path
  input  wire logic                    temp_valid_i,       // new temperature result
  input  wire logic [`SQ_DATA_W-1:0]   temp_data_i,        // compensated temperature
  input  wire logic                    pres_valid_i,       // new pressure result
  input  wire logic [`SQ_DATA_W-1:0]   pres_data_i,        // compensated pressure
  // host read side
  input  wire logic                    rd_req_i,           // one-cycle read request
  output logic                         rd_valid_o,         // one-cycle read answer
  output logic [`SQ_DATA_W-1:0]        rd_temp_o,          // temperature of read entry
  output logic [`SQ_DATA_W-1:0]        rd_pres_o,          // pressure of read entry
  // status
  output logic [1:0]                   operating_mode_o,   // stored policy select
  output logic [`SQ_PTR_W-1:0]         queue_level_threshold_o, // stored threshold
  output logic [`SQ_PTR_W-1:0]         queue_read_pointer_o,    // read pointer
  output logic [`SQ_PTR_W-1:0]         queue_write_pointer_o,   // write pointer
  output logic [`SQ_CNT_W-1:0]         level_o,            // entries stored, 0..32
  output logic                         empty_o,            // no entry stored
  output logic                         full_o,             // all 32 entries stored
  output logic                         err_insert_en_o,    // error codes allowed in reads
  output logic                         level_irq_o         // one-cycle level interrupt
);

  // operating control word fields
  logic [1:0]              operating_control_word;   // policy select field
  logic [`SQ_PTR_W-1:0]    queue_level_threshold;    // threshold field

  // pointers carry one extra wrap bit so full and empty differ
  logic [`SQ_CNT_W-1:0]    wr_ptr;                   // write pointer with wrap bit
  logic [`SQ_CNT_W-1:0]    rd_ptr;                   // read pointer with wrap bit
  logic [`SQ_CNT_W-1:0]    next_wr_ptr;              // write pointer after this edge
  logic [`SQ_CNT_W-1:0]    next_rd_ptr;              // read pointer after this edge

  // storage, one temperature and one pressure word per entry
  logic [`SQ_DATA_W-1:0]   temp_mem [`SQ_DEPTH];     // temperature half of entries
  logic [`SQ_DATA_W-1:0]   pres_mem [`SQ_DEPTH];     // pressure half of entries

  // latest temperature, repeated while no new one arrives
  logic [`SQ_DATA_W-1:0]   last_temp;                // most recent formatted temp

  // read answer and interrupt registers
  logic                    rd_valid;                 // answer strobe
  logic [`SQ_DATA_W-1:0]   rd_temp;                  // answer temperature
  logic [`SQ_DATA_W-1:0]   rd_pres;                  // answer pressure
  logic                    level_irq;                // interrupt pulse

  // decoded control
  sample_queue_pkg::queue_policy_type policy;        // current overflow policy
  logic                    enabled;                  // queue not off
  sample_queue_pkg::queue_policy_type mode_in_pol;   // policy being written now
  logic                    next_enabled;             // queue not off after this edge
  logic                    is_update;                // update policy active

  // status decode
  logic [`SQ_CNT_W-1:0]    count;                    // entries stored now
  logic [`SQ_CNT_W-1:0]    next_count;               // entries after this edge
  logic                    is_full;                  // all entries occupied
  logic                    is_empty;                 // nothing stored

  // write path decode
  logic [`SQ_DATA_W-1:0]   fmt_temp;                 // incoming temp, formatted
  logic [`SQ_DATA_W-1:0]   fmt_pres;                 // incoming pres, formatted
  logic [`SQ_DATA_W-1:0]   pair_temp;                // temp stored with this pres
  logic [`SQ_DATA_W-1:0]   store_temp;               // temp half, diag substituted
  logic [`SQ_DATA_W-1:0]   store_pres;               // pres half, diag substituted
  logic                    do_write;                 // entry written this edge
  logic                    do_read;                  // entry removed by host
  logic                    overwrite;                // oldest entry pushed out
  logic [`SQ_PTR_W-1:0]    wr_idx;                   // storage index for write
  logic [`SQ_PTR_W-1:0]    rd_idx;                   // storage index for read
  logic                    thr_on;                   // threshold not zero
  logic                    hit_thr;                  // count lands on threshold

  // policy decode, upper codes share update behaviour
  assign policy    = sample_queue_pkg::decode_policy(operating_control_word); // [R1]
  assign enabled   = (policy != sample_queue_pkg::policy_off);                // [R1]
  assign is_update = (policy == sample_queue_pkg::policy_update);             // [R1]
  // a control write acts on the pointers at the same edge that stores it,
  // so the stored mode never shows off while a pointer is still non-zero
  assign mode_in_pol  = sample_queue_pkg::decode_policy(ctrl_mode_i);         // [R1]
  assign next_enabled = ctrl_wr_i ? (mode_in_pol != sample_queue_pkg::policy_off) :
                        enabled;                                              // [R8]

  // count is the pointer difference; the wrap bit keeps 32 apart from 0
  assign count    = wr_ptr - rd_ptr;                  // [R16]
  assign is_full  = (count == `SQ_CNT_FULL);          // [R3]
  assign is_empty = (count == `SQ_PTR_ZERO);

  // filter off keeps the 22 significant bits and pads two zeros
  function automatic logic [`SQ_DATA_W-1:0] format_result(
    input logic                  filt_on,
    input logic [`SQ_DATA_W-1:0] raw
  );
    logic [`SQ_DATA_W-1:0] res;
    res = raw;                                                          // [R6]
    if (!filt_on)
      res = {raw[`SQ_DATA_W-1:`SQ_PAD_W], `SQ_PAD_ZERO};                // [R5]
    return res;
  endfunction : format_result

  assign fmt_temp = format_result(iir_enable_i, temp_data_i);
  assign fmt_pres = format_result(iir_enable_i, pres_data_i);

  // a temperature in the same cycle as the pressure is the newest one
  assign pair_temp  = temp_valid_i ? fmt_temp : last_temp;              // [R14]

  // diagnostics take the place of the compensated words
  assign store_temp = diag_enable_i ? diag_temp_i : pair_temp;          // [R7]
  assign store_pres = diag_enable_i ? diag_pres_i : fmt_pres;           // [R7]

  // reads only while something is stored; an empty read is ignored
  assign do_read   = enabled && rd_req_i && !is_empty;                  // [R15]
  // full mode drops when full, unless a read frees a slot in the same edge
  assign do_write  = enabled && pres_valid_i &&
                     (!is_full || is_update || do_read);                // [R10]
  // update mode on a full queue pushes the oldest entry out
  assign overwrite = do_write && is_full && is_update && !do_read;      // [R11]

  assign wr_idx = wr_ptr[`SQ_PTR_W-1:0];
  assign rd_idx = rd_ptr[`SQ_PTR_W-1:0];

  // pointer steps; both forced to zero while the queue is, or is being set, off
  assign next_wr_ptr = !next_enabled ? `SQ_PTR_ZERO :                   // [R8]
                       do_write ? wr_ptr + `SQ_CNT_ONE : wr_ptr;
  assign next_rd_ptr = !next_enabled ? `SQ_PTR_ZERO :                   // [R8]
                       (do_read || overwrite) ? rd_ptr + `SQ_CNT_ONE :  // [R11]
                       rd_ptr;                                          // [R15]
  assign next_count  = next_wr_ptr - next_rd_ptr;                       // [R16]

  // interrupt only on the write that brings the count onto the threshold
  assign thr_on  = (queue_level_threshold != `SQ_THR_OFF);              // [R12]
  assign hit_thr = thr_on && do_write &&
                   (next_count == {1'b0, queue_level_threshold}) &&
                   (count != {1'b0, queue_level_threshold});            // [R13]

  // control word; starts with the queue off
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      operating_control_word <= `SQ_MODE_RESET;                         // [R2]
      queue_level_threshold  <= `SQ_THR_RESET;
    end
    else if (ctrl_wr_i)
    begin
      operating_control_word <= ctrl_mode_i;
      queue_level_threshold  <= ctrl_threshold_i;                       // [R12]
    end
  end

  // pointer registers
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_ptr <= `SQ_PTR_ZERO;
      rd_ptr <= `SQ_PTR_ZERO;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // latest temperature is kept even while the queue is off
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      last_temp <= `SQ_DATA_ZERO;
    else if (temp_valid_i)
      last_temp <= fmt_temp;                                            // [R14]
  end

  // storage entries; no reset needed on data, but reset keeps reads defined
  genvar e;
  generate
    for (e = 0; e < `SQ_DEPTH; e++)
    begin : g_entry
      logic hit;                                                        // this entry written
      assign hit = do_write && (wr_idx == `SQ_PTR_W'(e));
      always_ff @(posedge ref_clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          temp_mem[e] <= `SQ_DATA_ZERO;
          pres_mem[e] <= `SQ_DATA_ZERO;
        end
        else if (hit)
        begin
          temp_mem[e] <= store_temp;                                    // [R3]
          pres_mem[e] <= store_pres;
        end
      end
    end
  endgenerate

  // read answer: oldest entry, registered, one cycle after the request
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rd_valid <= 1'b0;
      rd_temp  <= `SQ_DATA_ZERO;
      rd_pres  <= `SQ_DATA_ZERO;
    end
    else
    begin
      rd_valid <= do_read;                                              // [R15]
      if (do_read)
      begin
        rd_temp <= temp_mem[rd_idx];                                    // [R4]
        rd_pres <= pres_mem[rd_idx];                                    // [R4]
      end
    end
  end

  // interrupt pulse lines up with the count that reached the threshold
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      level_irq <= 1'b0;
    else
      level_irq <= hit_thr;                                             // [R13]
  end

  // outputs
  assign rd_valid_o              = rd_valid;
  assign rd_temp_o               = rd_temp;
  assign rd_pres_o               = rd_pres;
  assign operating_mode_o        = operating_control_word;
  assign queue_level_threshold_o = queue_level_threshold;
  assign queue_read_pointer_o    = rd_idx;
  assign queue_write_pointer_o   = wr_idx;
  assign level_o                 = count;
  assign empty_o                 = is_empty;
  assign full_o                  = is_full;
  // error codes on result reads only while the queue is in use
  assign err_insert_en_o         = enabled;                             // [R9]
  assign level_irq_o             = level_irq;

endmodule : sample_queue_with_threshold

// ==== sample_queue_sva.sv ====
// Purpose: port checks for the sample queue
// Assumes: one clock domain, reset active low
// Notes:   bound to every queue instance
`timescale 1ns/1ns
module sample_queue_sva (
  input wire logic       ref_clk_i,
  input wire logic       rst_n_i,
  input wire logic       ctrl_wr_i,
  input wire logic [1:0] ctrl_mode_i,
  input wire logic       pres_valid_i,
  input wire logic       rd_req_i,
  input wire logic       rd_valid_o,
  input wire logic [1:0] operating_mode_o,
  input wire logic [4:0] queue_level_threshold_o,
  input wire logic [4:0] queue_read_pointer_o,
  input wire logic [4:0] queue_write_pointer_o,
  input wire logic [5:0] level_o,
  input wire logic       empty_o,
  input wire logic       full_o,
  input wire logic       err_insert_en_o,
  input wire logic       level_irq_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  wire off = operating_mode_o == 2'h0;  // queue disabled
  // a write into a full queue with no read to free a slot, with the control word left alone
  wire lone_wr = pres_valid_i && !rd_req_i && !ctrl_wr_i && full_o;

  a_mode_store: assert property (ctrl_wr_i |=> operating_mode_o == $past(ctrl_mode_i))
    else $error("policy select not stored");
  a_ptr_off: assert property (off |->
    queue_read_pointer_o == 5'h00 && queue_write_pointer_o == 5'h00)
    else $error("pointers not zero while off");
  a_err_off: assert property (err_insert_en_o == !off)
    else $error("error coding enable wrong");
  a_depth_max: assert property (level_o <= 6'h20 && full_o == (level_o == 6'h20))
    else $error("level beyond depth");
  a_level_ptr: assert property (
    level_o[4:0] == queue_write_pointer_o - queue_read_pointer_o &&
    empty_o == (level_o == 6'h00))
    else $error("level differs from pointers");
  a_full_drop: assert property (operating_mode_o == 2'h1 && lone_wr |=>
    $stable(queue_write_pointer_o) && full_o)
    else $error("full mode wrote past capacity");
  a_upd_wrap: assert property (operating_mode_o[1] && lone_wr |=> full_o &&
    queue_read_pointer_o - $past(queue_read_pointer_o) == 5'h01)
    else $error("update mode did not push read pointer");
  a_irq_off: assert property (queue_level_threshold_o == 5'h00 |-> !level_irq_o)
    else $error("interrupt with threshold off");
  a_irq_cause: assert property (level_irq_o |->
    level_o == {1'b0, queue_level_threshold_o} && $past(pres_valid_i))
    else $error("interrupt without reaching threshold");
  a_irq_fire: assert property (!off && pres_valid_i && !rd_req_i && !ctrl_wr_i &&
    queue_level_threshold_o != 5'h00 &&
    level_o + 6'h01 == {1'b0, queue_level_threshold_o} |=> level_irq_o)
    else $error("interrupt missed at threshold");
  a_rd_answer: assert property (rd_req_i && !empty_o && !off |=> rd_valid_o)
    else $error("read not answered");
  a_rd_refuse: assert property (rd_req_i && empty_o |=> !rd_valid_o)
    else $error("empty read answered");
endmodule : sample_queue_sva

bind sample_queue_with_threshold sample_queue_sva i_sva (.ref_clk_i, .rst_n_i, .ctrl_wr_i,
  .ctrl_mode_i, .pres_valid_i, .rd_req_i, .rd_valid_o, .operating_mode_o,
  .queue_level_threshold_o, .queue_read_pointer_o, .queue_write_pointer_o, .level_o,
  .empty_o, .full_o, .err_insert_en_o, .level_irq_o);

// ==== sample_host_model.sv ====
// Purpose: host that pulls entries out of the sample queue
// Assumes: answer is registered on the same edge that takes the request
// Notes:   gap stalls the host to mimic a slow serial bus
`timescale 1ns/1ns
module sample_host_model (
  input  wire logic        ref_clk_i,
  input  wire logic        rd_valid_i,
  input  wire logic [23:0] rd_temp_i,
  input  wire logic [23:0] rd_pres_i,
  output logic             rd_req_o
);
  initial rd_req_o = 1'b0;
  // one read: a single pulse, answer taken once it has settled
  task automatic read(input int gap, output logic ok,
                      output logic [23:0] t, output logic [23:0] p);
    repeat (gap) @(posedge ref_clk_i);
    @(posedge ref_clk_i);
    rd_req_o <= 1'b1;
    @(posedge ref_clk_i);
    rd_req_o <= 1'b0;
    #1;
    ok = rd_valid_i;
    t = rd_temp_i;
    p = rd_pres_i;
  endtask : read
endmodule : sample_host_model

// ==== test_sample_queue_with_threshold.sv ====
// Purpose: self-checking bench for the sample queue
// Assumes: host model owns the read request
// Notes:   format rows in a table, overflow cases by hand
`timescale 1ns/1ns
module test_sample_queue_with_threshold;
  typedef struct {
    logic iir, dg, tv;
    logic [23:0] t, p, et, ep;
  } row_type;
  // filter off, filter on, repeated temperature, diagnostics
  row_type rows[4] = '{
    '{1'b0, 1'b0, 1'b1, 24'h65_4323, 24'h0f_0f0f, 24'h65_4320, 24'h0f_0f0c},
    '{1'b1, 1'b0, 1'b1, 24'h12_3457, 24'hab_cdef, 24'h12_3457, 24'hab_cdef},
    '{1'b1, 1'b0, 1'b0, 24'h00_0000, 24'h11_1111, 24'h12_3457, 24'h11_1111},
    '{1'b0, 1'b1, 1'b1, 24'h00_0000, 24'h22_2222, 24'h5a_a5c3, 24'h3c_c3e7}};
  logic ref_clk = 1'b0, rst_n = 1'b0, ctrl_wr = 1'b0, iir = 1'b1, diag = 1'b0;
  logic tv = 1'b0, pv = 1'b0, rd_req, rd_valid, empty, full, err_en, irq, ok;
  logic [1:0]  mode = 2'h0, mode_q;
  logic [4:0]  thr = 5'h00, thr_q, rptr, wptr;
  logic [5:0]  level;
  logic [23:0] tdat = 24'h00_0000, pdat = 24'h00_0000, rd_t, rd_p, t, p;
  int          fails = 0, num_checks = 0, irqs = 0, cycles = 0;

  always #2 ref_clk = ~ref_clk;
  // count level interrupts; cut a hang short
  always @(posedge ref_clk)
  begin
    if (irq === 1'b1) irqs++;
    cycles++;
    if (cycles == 3000)
    begin
      fails++;
      stop_test();
    end
  end

  sample_queue_with_threshold i_dut (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .ctrl_wr_i(ctrl_wr),
    .ctrl_mode_i(mode), .ctrl_threshold_i(thr), .iir_enable_i(iir), .diag_enable_i(diag),
    .diag_temp_i(24'h5a_a5c3), .diag_pres_i(24'h3c_c3e7), .temp_valid_i(tv), .temp_data_i(tdat),
    .pres_valid_i(pv), .pres_data_i(pdat), .rd_req_i(rd_req), .rd_valid_o(rd_valid),
    .rd_temp_o(rd_t), .rd_pres_o(rd_p), .operating_mode_o(mode_q),
    .queue_level_threshold_o(thr_q), .queue_read_pointer_o(rptr), .queue_write_pointer_o(wptr),
    .level_o(level), .empty_o(empty), .full_o(full), .err_insert_en_o(err_en),
    .level_irq_o(irq));
  sample_host_model i_host (.ref_clk_i(ref_clk), .rd_valid_i(rd_valid), .rd_temp_i(rd_t),
    .rd_pres_i(rd_p), .rd_req_o(rd_req));

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    num_checks++;
    if (got !== exp)
    begin
      $display("unexpected %s: expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask : chk
  // control word write, one strobe
  task automatic setc(input logic [1:0] m, input logic [4:0] th);
    @(posedge ref_clk);
    ctrl_wr <= 1'b1;
    mode <= m;
    thr <= th;
    @(posedge ref_clk);
    ctrl_wr <= 1'b0;
    #1;
  endtask : setc
  // n back-to-back results, pressure counting up from p
  task automatic push(input int n, input logic tvv, input logic [23:0] tt, input logic [23:0] pp);
    for (int i = 0; i < n; i++)
    begin
      @(posedge ref_clk);
      pv <= 1'b1;
      tv <= tvv;
      tdat <= tt;
      pdat <= pp + 24'(i);
    end
    @(posedge ref_clk);
    pv <= 1'b0;
    tv <= 1'b0;
    #1;
  endtask : push
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  initial
  begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1;
    chk("reset mode", 24'h00_0000, 24'(mode_q));
    chk("reset ptrs", 24'h00_0800, 24'({empty, err_en, rptr, wptr}));
    // every policy code: off stores nothing, the rest store and answer
    for (int m = 0; m < 4; m++)
    begin
      setc(2'(m), 5'h00);
      push(1, 1'b0, 24'h00_0000, 24'h00_0004);
      chk("mode", 24'(m), 24'(mode_q));
      chk("level", 24'(m != 0), 24'(level));
      chk("err enable", 24'(m != 0), 24'(err_en));
      i_host.read(0, ok, t, p);
      chk("read ok", 24'(m != 0), 24'(ok));
    end
    i_host.read(2, ok, t, p);
    chk("empty read", 24'h00_0000, 24'(ok));
    foreach (rows[i])
    begin
      @(posedge ref_clk);
      iir <= rows[i].iir;
      diag <= rows[i].dg;
      push(1, rows[i].tv, rows[i].t, rows[i].p);
      i_host.read(1, ok, t, p);
      chk("row temp", rows[i].et, t);
      chk("row pres", rows[i].ep, p);
    end
    @(posedge ref_clk);
    iir <= 1'b1;
    diag <= 1'b0;
    // empty the queue, fill past capacity in full mode, drain with a stalling host
    setc(2'h0, 5'h00);
    chk("off ptrs", 24'h00_0000, 24'({rptr, wptr}));
    setc(2'h1, 5'h05);
    chk("threshold", 24'h00_0005, 24'(thr_q));
    irqs = 0;
    push(33, 1'b1, 24'h00_0000, 24'h00_0100);
    chk("full level", 24'h00_0020, 24'(level));
    chk("full flag", 24'h00_0001, 24'(full));
    chk("wr ptr", 24'h00_0000, 24'(wptr));
    for (int i = 0; i < 32; i++)
    begin
      i_host.read(i % 3, ok, t, p);
      chk("order", 24'h00_0100 + 24'(i), p);
    end
    chk("irq count", 24'h00_0001, 24'(irqs));
    // update mode overwrites the two oldest, threshold off
    setc(2'h0, 5'h00);
    setc(2'h2, 5'h00);
    irqs = 0;
    push(34, 1'b1, 24'h00_0000, 24'h00_0200);
    chk("rd ptr", 24'h00_0002, 24'(rptr));
    chk("upd wr ptr", 24'h00_0002, 24'(wptr));
    chk("upd level", 24'h00_0020, 24'(level));
    chk("irq off", 24'h00_0000, 24'(irqs));
    i_host.read(0, ok, t, p);
    chk("oldest", 24'h00_0202, p);
    // reset in mid-run with a filled queue, then use the queue again
    @(posedge ref_clk);
    rst_n <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk("mid reset ptrs", 24'h00_0800, 24'({empty, err_en, rptr, wptr}));
    chk("mid reset ctrl", 24'h00_0000, 24'({mode_q, thr_q}));
    @(posedge ref_clk);
    rst_n <= 1'b1;
    setc(2'h1, 5'h00);
    push(1, 1'b1, 24'h00_0000, 24'h00_0300);
    chk("level after reset", 24'h00_0001, 24'(level));
    stop_test();
  end
endmodule : test_sample_queue_with_threshold
